// ---- verification/pad_board_model.sv ----
// Purpose: Board-side model of a group of pads with pulls and an outside driver.
// Assumes: One clock; the outside driver acts only while its enable is high.
// Notes: A pad nobody drives or pulls shows a level that flips every cycle.
`timescale 1ns/1ps
module pad_board_model
#(
    parameter int N = 8
)
(
    // Clock.
    input wire logic clk_i,
    // Device side.
    input wire logic [N-1:0] pad_drv_i,
    input wire logic [N-1:0] pad_oe_i,
    input wire logic [N-1:0] pull_up_i,
    input wire logic [N-1:0] pull_down_i,
    // Board side.
    input wire logic [N-1:0] ext_drv_i,
    input wire logic [N-1:0] ext_en_i,
    output logic [N-1:0] pad_o
);
    logic [N-1:0] float_q = '0;

    always_ff @(posedge clk_i)
    begin
        float_q <= ~float_q;
    end

    always_comb
    begin
        for (int i = 0; i < N; i++)
        begin
            if (pad_oe_i[i])
                pad_o[i] = pad_drv_i[i];
            else if (ext_en_i[i])
                pad_o[i] = ext_drv_i[i];
            else if (pull_up_i[i])
                pad_o[i] = 1'b1;
            else if (pull_down_i[i])
                pad_o[i] = 1'b0;
            else
                pad_o[i] = float_q[i];
        end
    end
endmodule : pad_board_model

// ---- verification/tb_top.sv ----
// Purpose: Self-checking bench for the port K/L pin control block.
// Assumes: Wishbone answer one cycle after the request is taken.
// Notes: Only mapped offsets and one unmapped offset are touched.
`timescale 1ns/1ps
module tb_top;
    import pin_ctrl_pkg::*;
    typedef struct packed {logic [7:0] a; logic [31:0] v;} row_t;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat_w = 32'h0;
    logic [19:0] pv = 20'h0;
    logic [4:0] k_data = 5'h00, k_oe = 5'h00, ext_k = 5'h00, ext_k_en = 5'h00;
    logic [7:0] ext_l = 8'h00, ext_l_en = 8'h00;
    logic usb_act = 1'b0;
    int fails = 0, cmp_count = 0, cycles = 0;
    wire [31:0] dat_r;
    wire ack, emg, ext_interrupt_two, ext_interrupt_eight, ext_interrupt_d, sck, sic, sod;
    wire [7:0] l_pin_i, l_pin_o, l_oe, l_pu, l_pd;
    wire [4:0] k_pin_i, k_pin_o, k_oe_o, k_pu, k_pd, k_in;
    wire [3:0] eth_d, eth_c;
    wire [7:0] l_per;
    // Offset 0x40 is unmapped; the reserved offsets are never touched.
    row_t rows [19] = '{'{OFS_L_DATA, 32'hFF}, '{OFS_L_OE, 32'hFF}, '{OFS_L_FS1, 32'hFF},
        '{OFS_L_FS2, 32'hFF}, '{OFS_L_FS3, 32'h0F}, '{OFS_L_FS4, 32'h0F},
        '{OFS_L_FS5, 32'h0E}, '{OFS_L_FS6, 32'h08}, '{OFS_L_OD, 32'hFF},
        '{OFS_L_PU, 32'hFF}, '{OFS_L_PD, 32'hFF}, '{OFS_L_IE, 32'hFF},
        '{OFS_K_FS3, 32'h1E}, '{OFS_K_FS4, 32'h02}, '{OFS_K_OD, 32'h1F},
        '{OFS_K_PU, 32'h1F}, '{OFS_K_PD, 32'h1F}, '{OFS_K_IE, 32'h1F}, '{8'h40, 32'h00}};

    pin_ctrl_kl uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r),
        .wb_ack_o(ack), .l_pin_i(l_pin_i), .l_pin_o(l_pin_o), .l_pin_oe_o(l_oe),
        .l_pullup_o(l_pu), .l_pulldown_o(l_pd), .k_pin_i(k_pin_i), .k_data_i(k_data),
        .k_oe_i(k_oe), .usb_dev_active_i(usb_act), .k_pin_o(k_pin_o), .k_pin_oe_o(k_oe_o),
        .k_pullup_o(k_pu), .k_pulldown_o(k_pd), .k_in_o(k_in), .eth_receive_data_o(eth_d),
        .eth_receive_error_o(eth_c[3]), .eth_receive_valid_o(eth_c[2]),
        .eth_carrier_sense_o(eth_c[1]), .eth_receive_clock_o(eth_c[0]),
        .motor_emergency_in_o(emg), .ext_interrupt_two_o(ext_interrupt_two),
        .gate_emergency_in_o(l_per[7]), .motor_timer_in_o(l_per[6]),
        .motor_timerb_in_o(l_per[5]), .dac_trigger_in_o(l_per[4]),
        .adc_unit_a_trigger_o(l_per[3]), .serial2_receive_o(l_per[2]),
        .serial2_clear_to_send_o(l_per[1]), .serial2_clock_in_o(l_per[0]),
        .motor_phase_i(pv[5:0]), .motor_timer_out_a_i(pv[6]),
        .motor_timer_out_b_i(pv[7]), .motor_timerb_out_i(pv[8]), .serial2_transmit_i(pv[9]),
        .serial2_clock_i(pv[10]), .serial2_clock_oe_i(pv[11]), .sio0_clock_i(pv[12]),
        .sio0_clock_oe_i(pv[13]), .sio0_out_or_i2c_data_i(pv[14]),
        .sio0_out_or_i2c_data_oe_i(pv[15]), .sio0_in_or_i2c_clock_i(pv[16]),
        .sio0_in_or_i2c_clock_oe_i(pv[17]), .timerb6_output_i(pv[18]),
        .usb_dev_pullup_ctrl_i(pv[19]), .sio0_clock_o(sck), .sio0_in_or_i2c_clock_o(sic),
        .sio0_out_or_i2c_data_o(sod), .ext_interrupt_eight_o(ext_interrupt_eight), .ext_interrupt_d_o(ext_interrupt_d));
    pad_board_model #(.N(8)) l_board (.clk_i(clk_i), .pad_drv_i(l_pin_o), .pad_oe_i(l_oe),
        .pull_up_i(l_pu), .pull_down_i(l_pd), .ext_drv_i(ext_l), .ext_en_i(ext_l_en),
        .pad_o(l_pin_i));
    pad_board_model #(.N(5)) k_board (.clk_i(clk_i), .pad_drv_i(k_pin_o), .pad_oe_i(k_oe_o),
        .pull_up_i(k_pu), .pull_down_i(k_pd), .ext_drv_i(ext_k), .ext_en_i(ext_k_en),
        .pad_o(k_pin_i));

    always #2.5 clk_i = ~clk_i;

    // A hang is cut short here and counted as a mismatch.
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fails++;
            test_done();
        end
    end

    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e)
        begin
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
            fails++;
        end
    endtask : chk

    // One classic cycle; released only at the edge where the answer is seen.
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
        @(posedge clk_i);
        {cyc, stb, we, adr, sel, dat_w} <= {2'b11, w, a, 4'hF, d};
        do
            @(posedge clk_i);
        while (ack !== 1'b1);
        r = dat_r;
        {cyc, stb, we} <= 3'b000;
    endtask : wb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        wb(1'b1, a, d, r);
    endtask : wr

    task automatic rdchk(input string n, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        wb(1'b0, a, 32'h0, r);
        chk(n, r, e);
    endtask : rdchk

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : test_done

    initial
    begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (rows[i])
        begin
            wr(rows[i].a, 32'hFFFF_FFFF);
            rdchk("reg_mask", rows[i].a, rows[i].v);
            if (i inside {[2:7], 12, 13})
                wr(rows[i].a, 32'h0);
        end
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        chk("oe_reset", {l_oe, l_pu}, 32'h0);
        foreach (rows[i])
            rdchk("reg_reset", rows[i].a, 32'h0);
        wr(OFS_L_OE, 32'hFF);
        wr(OFS_L_DATA, 32'hA5);
        @(negedge clk_i);
        chk("drive", {l_pin_o, l_oe}, 32'hA5FF);
        wr(OFS_L_OD, 32'hFF);
        wr(OFS_L_PU, 32'hFF);
        wr(OFS_L_IE, 32'hFF);
        @(negedge clk_i);
        chk("open_drain", {l_pin_o, l_oe, l_pu}, 32'h005AFF);
        rdchk("pad_read", OFS_L_DATA, 32'hA5);
        wr(OFS_L_OE, 32'h00);
        wr(OFS_L_PU, 32'h00);
        wr(OFS_L_PD, 32'hFF);
        rdchk("pulled_low", OFS_L_DATA, 32'h00);
        ext_l <= 8'h96;
        ext_l_en <= 8'hFF;
        wr(OFS_L_FS1, 32'hFF);
        @(negedge clk_i);
        chk("eth_rx", {eth_d, eth_c}, 32'h96);
        wr(OFS_L_FS1, 32'h00);
        wr(OFS_L_OD, 32'h00);
        pv[5:0] <= 6'h2D;
        wr(OFS_L_FS2, 32'hFF);
        @(negedge clk_i);
        chk("pwm", {l_pin_o[7:2], l_oe[7:2], emg, ext_interrupt_two}, 32'h2DFE);
        wr(OFS_L_IE, 32'h00);
        ext_k <= 5'b01010;
        ext_k_en <= 5'h1F;
        @(negedge clk_i);
        chk("in_off", {eth_d, emg}, 32'h0);
        wr(OFS_L_FS2, 32'h00);
        wr(OFS_L_IE, 32'hFF);
        pv[7:6] <= 2'b01;
        wr(OFS_L_FS3, 32'h0F);
        @(negedge clk_i);
        chk("l_sel3", {l_pin_o[3:2], l_oe[3:2], l_per[7:6]}, 32'h2E);
        wr(OFS_L_FS3, 32'h00);
        pv[8] <= 1'b1;
        wr(OFS_L_FS4, 32'h0F);
        @(negedge clk_i);
        chk("l_sel4", {l_pin_o[3], l_oe[3], l_per[5:3]}, 32'h1E);
        wr(OFS_L_FS4, 32'h00);
        ext_l <= 8'h0A;
        pv[11:9] <= 3'b011;
        wr(OFS_L_FS5, 32'h0E);
        @(negedge clk_i);
        chk("l_sel5", {l_pin_o[2], l_oe[2], l_oe[3], l_per[2], l_per[0]}, 32'h1B);
        wr(OFS_L_FS5, 32'h00);
        wr(OFS_L_FS6, 32'h08);
        @(negedge clk_i);
        chk("l_sel6", {l_per[1], l_per[2], l_per[0]}, 32'h4);
        wr(OFS_K_IE, 32'h1F);
        wr(OFS_K_FS3, 32'h1E);
        @(negedge clk_i);
        chk("k_sel3", {k_in, ext_interrupt_eight, sck, sic, sod}, 32'h0AA);
        wr(OFS_K_FS3, 32'h00);
        pv[18] <= 1'b1;
        wr(OFS_K_FS4, 32'h02);
        @(negedge clk_i);
        chk("k_tb6", {k_pin_o[1], k_oe_o[1]}, 32'h3);
        @(posedge clk_i);
        usb_act <= 1'b1;
        pv[19] <= 1'b1;
        @(negedge clk_i);
        chk("usb_pu", {k_pin_o[0], ext_interrupt_d}, 32'h2);
        @(posedge clk_i);
        usb_act <= 1'b0;
        ext_k[0] <= 1'b1;
        @(negedge clk_i);
        chk("int_d", ext_interrupt_d, 32'h1);
        test_done();
    end
endmodule : tb_top

// ---- verilog/pin_ctrl_kl.sv ----
// Purpose: Pin control for eight-pin port L and the later port K controls.
// Assumes: Classic Wishbone slave; pin inputs synchronous to clk_i.
// Notes: Alternate-function routing is a priority mux per pin.
// Operation
// - L select one routes Ethernet receive pins
// - L select two routes PWM, emergency, interrupt
// - L select three bits 3..0 only
// - L select four timer B, DAC, ADC triggers
// - L select five bits 3..1 serial two
// - L select six bit 3 clear-to-send
// - K select three bits 4..1, SIO, interrupt
// - K select four bit 1 timer B six
// - L data register drives general outputs
// - Output-control bit enables pin driver
// - Open-drain bit drives low only
// - Pull-up bit enables internal pull-up
// - Pull-down bit enables internal pull-down
// - Input bit passes pin level inward
// - Bits above implemented pins read zero
// - All registers reset to zero
// - L data, control, selects at fixed offsets
// - L open-drain, pulls, input at offsets
// - K pin zero serves USB pull-up control
//
// Chosen here: register access over Wishbone.
`timescale 1ns/1ps
module pin_ctrl_kl
    import pin_ctrl_pkg::*;
#(
    parameter int NL = pin_ctrl_pkg::L_PINS,
    parameter int NK = pin_ctrl_pkg::K_PINS
)
(
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave.
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [pin_ctrl_pkg::ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Port L pins.
    input wire logic [7:0] l_pin_i,
    output logic [7:0] l_pin_o,
    output logic [7:0] l_pin_oe_o,
    output logic [7:0] l_pullup_o,
    output logic [7:0] l_pulldown_o,
    // Port K pins (only the later controls are held here).
    input wire logic [4:0] k_pin_i,
    input wire logic [4:0] k_data_i,
    input wire logic [4:0] k_oe_i,
    input wire logic usb_dev_active_i,
    output logic [4:0] k_pin_o,
    output logic [4:0] k_pin_oe_o,
    output logic [4:0] k_pullup_o,
    output logic [4:0] k_pulldown_o,
    output logic [4:0] k_in_o,
    // Port L peripheral inputs (pin to peripheral).
    output logic [3:0] eth_receive_data_o,
    output logic eth_receive_error_o,
    output logic eth_receive_valid_o,
    output logic eth_carrier_sense_o,
    output logic eth_receive_clock_o,
    output logic motor_emergency_in_o,
    output logic ext_interrupt_two_o,
    output logic gate_emergency_in_o,
    output logic motor_timer_in_o,
    output logic motor_timerb_in_o,
    output logic dac_trigger_in_o,
    output logic adc_unit_a_trigger_o,
    output logic serial2_receive_o,
    output logic serial2_clear_to_send_o,
    output logic serial2_clock_in_o,
    // Port L peripheral outputs (peripheral to pin), order U X V Y W Z.
    input wire logic [5:0] motor_phase_i,
    input wire logic motor_timer_out_a_i,
    input wire logic motor_timer_out_b_i,
    input wire logic motor_timerb_out_i,
    input wire logic serial2_transmit_i,
    input wire logic serial2_clock_i,
    input wire logic serial2_clock_oe_i,
    // Port K peripherals.
    input wire logic sio0_clock_i,
    input wire logic sio0_clock_oe_i,
    input wire logic sio0_out_or_i2c_data_i,
    input wire logic sio0_out_or_i2c_data_oe_i,
    input wire logic sio0_in_or_i2c_clock_i,
    input wire logic sio0_in_or_i2c_clock_oe_i,
    input wire logic timerb6_output_i,
    input wire logic usb_dev_pullup_ctrl_i,
    output logic sio0_clock_o,
    output logic sio0_in_or_i2c_clock_o,
    output logic sio0_out_or_i2c_data_o,
    output logic ext_interrupt_eight_o,
    output logic ext_interrupt_d_o
);
    import pin_ctrl_pkg::*;

    // ==========================================================
    // Registers
    // ==========================================================
    logic [7:0] l_data_q, l_oe_q, l_fs1_q, l_fs2_q, l_fs3_q, l_fs4_q;
    logic [7:0] l_fs5_q, l_fs6_q, l_od_q, l_pu_q, l_pd_q, l_ie_q;
    logic [4:0] k_fs3_q, k_fs4_q, k_od_q, k_pu_q, k_pd_q, k_ie_q;
    logic ack_q;
    logic [31:0] rdata_q;
    logic req;
    logic wr;
    logic [7:0] wb0;
    logic [7:0] l_in;
    logic [4:0] k_in;

    assign req = wb_cyc_i && wb_stb_i && !ack_q;
    assign wr = req && wb_we_i && wb_sel_i[0];
    assign wb0 = wb_dat_i[7:0];

    // Registers answer one cycle after the request; ack drops a cycle later.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_q <= 1'b0;
        end
        else
        begin
            ack_q <= req;
        end
    end
    assign wb_ack_o = ack_q;

    // Write decode; only byte lane 0 carries implemented bits.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            l_data_q <= RST_L;
            l_oe_q <= RST_L;
            l_fs1_q <= RST_L;
            l_fs2_q <= RST_L;
            l_fs3_q <= RST_L;
            l_fs4_q <= RST_L;
            l_fs5_q <= RST_L;
            l_fs6_q <= RST_L;
            l_od_q <= RST_L;
            l_pu_q <= RST_L;
            l_pd_q <= RST_L;
            l_ie_q <= RST_L;
            k_fs3_q <= RST_K;
            k_fs4_q <= RST_K;
            k_od_q <= RST_K;
            k_pu_q <= RST_K;
            k_pd_q <= RST_K;
            k_ie_q <= RST_K;
        end
        else if (wr)
        begin
            unique case (wb_adr_i)
                OFS_L_DATA: l_data_q <= wb0 & MASK_L_ALL;
                OFS_L_OE: l_oe_q <= wb0 & MASK_L_ALL;
                OFS_L_FS1: l_fs1_q <= wb0 & MASK_L_ALL;
                OFS_L_FS2: l_fs2_q <= wb0 & MASK_L_ALL;
                OFS_L_FS3: l_fs3_q <= wb0 & MASK_L_LOW4;
                OFS_L_FS4: l_fs4_q <= wb0 & MASK_L_LOW4;
                OFS_L_FS5: l_fs5_q <= wb0 & MASK_L_FS5;
                OFS_L_FS6: l_fs6_q <= wb0 & MASK_L_FS6;
                OFS_L_OD: l_od_q <= wb0 & MASK_L_ALL;
                OFS_L_PU: l_pu_q <= wb0 & MASK_L_ALL;
                OFS_L_PD: l_pd_q <= wb0 & MASK_L_ALL;
                OFS_L_IE: l_ie_q <= wb0 & MASK_L_ALL;
                OFS_K_FS3: k_fs3_q <= wb0[4:0] & MASK_K_FS3;
                OFS_K_FS4: k_fs4_q <= wb0[4:0] & MASK_K_FS4;
                OFS_K_OD: k_od_q <= wb0[4:0] & MASK_K_ALL;
                OFS_K_PU: k_pu_q <= wb0[4:0] & MASK_K_ALL;
                OFS_K_PD: k_pd_q <= wb0[4:0] & MASK_K_ALL;
                OFS_K_IE: k_ie_q <= wb0[4:0] & MASK_K_ALL;
                default:
                begin
                end
            endcase
        end
    end

    // ==========================================================
    // Read path
    // ==========================================================
    // Upper bits are zero-extended; reserved offsets read zero.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rdata_q <= READ_UNMAPPED;
        end
        else if (req)
        begin
            unique case (wb_adr_i)
                OFS_L_DATA: rdata_q <= {24'h000000, (l_data_q & ~l_ie_q) | l_in};
                OFS_L_OE: rdata_q <= {24'h000000, l_oe_q};
                OFS_L_FS1: rdata_q <= {24'h000000, l_fs1_q};
                OFS_L_FS2: rdata_q <= {24'h000000, l_fs2_q};
                OFS_L_FS3: rdata_q <= {24'h000000, l_fs3_q};
                OFS_L_FS4: rdata_q <= {24'h000000, l_fs4_q};
                OFS_L_FS5: rdata_q <= {24'h000000, l_fs5_q};
                OFS_L_FS6: rdata_q <= {24'h000000, l_fs6_q};
                OFS_L_OD: rdata_q <= {24'h000000, l_od_q};
                OFS_L_PU: rdata_q <= {24'h000000, l_pu_q};
                OFS_L_PD: rdata_q <= {24'h000000, l_pd_q};
                OFS_L_IE: rdata_q <= {24'h000000, l_ie_q};
                OFS_K_FS3: rdata_q <= {27'h0000000, k_fs3_q};
                OFS_K_FS4: rdata_q <= {27'h0000000, k_fs4_q};
                OFS_K_OD: rdata_q <= {27'h0000000, k_od_q};
                OFS_K_PU: rdata_q <= {27'h0000000, k_pu_q};
                OFS_K_PD: rdata_q <= {27'h0000000, k_pd_q};
                OFS_K_IE: rdata_q <= {27'h0000000, k_ie_q};
                default: rdata_q <= READ_UNMAPPED;
            endcase
        end
    end
    assign wb_dat_o = rdata_q;

    // ==========================================================
    // Port L pads
    // ==========================================================
    assign l_in = l_pin_i & l_ie_q;
    assign l_pullup_o = l_pu_q;
    assign l_pulldown_o = l_pd_q;

    genvar gi;
    generate
        for (gi = 0; gi < NL; gi++)
        begin : g_l
            logic drv;
            logic en;
            // Peripheral-output selections override the data register.
            always_comb
            begin
                drv = l_data_q[gi];
                en = l_oe_q[gi];
                if (gi >= 2 && l_fs2_q[gi])
                begin
                    drv = motor_phase_i[(gi >= 2) ? 7 - gi : 0];
                    en = 1'b1;
                end
                else if (gi == 3 && l_fs3_q[gi])
                begin
                    drv = motor_timer_out_a_i;
                    en = 1'b1;
                end
                else if (gi == 2 && l_fs3_q[gi])
                begin
                    drv = motor_timer_out_b_i;
                    en = 1'b1;
                end
                else if (gi == 3 && l_fs4_q[gi])
                begin
                    drv = motor_timerb_out_i;
                    en = 1'b1;
                end
                else if (gi == 2 && l_fs5_q[gi])
                begin
                    drv = serial2_transmit_i;
                    en = 1'b1;
                end
                else if (gi == 3 && l_fs5_q[gi])
                begin
                    drv = serial2_clock_i;
                    en = serial2_clock_oe_i;
                end
                // Open drain drives only a low level.
                l_pin_o[gi] = l_od_q[gi] ? 1'b0 : drv;
                l_pin_oe_o[gi] = en && !(l_od_q[gi] && drv);
            end
        end
    endgenerate

    // Pin-to-peripheral inputs gated by their select bits.
    assign eth_receive_data_o = l_in[7:4] & l_fs1_q[7:4];
    assign eth_receive_error_o = l_in[3] & l_fs1_q[3];
    assign eth_receive_valid_o = l_in[2] & l_fs1_q[2];
    assign eth_carrier_sense_o = l_in[1] & l_fs1_q[1];
    assign eth_receive_clock_o = l_in[0] & l_fs1_q[0];
    assign motor_emergency_in_o = l_in[1] & l_fs2_q[1];
    assign ext_interrupt_two_o = l_in[0] & l_fs2_q[0];
    assign gate_emergency_in_o = l_in[1] & l_fs3_q[1];
    assign motor_timer_in_o = l_in[0] & l_fs3_q[0];
    assign motor_timerb_in_o = l_in[2] & l_fs4_q[2];
    assign dac_trigger_in_o = l_in[1] & l_fs4_q[1];
    assign adc_unit_a_trigger_o = l_in[0] & l_fs4_q[0];
    assign serial2_receive_o = l_in[1] & l_fs5_q[1];
    assign serial2_clock_in_o = l_in[3] & l_fs5_q[3];
    assign serial2_clear_to_send_o = l_in[3] & l_fs6_q[3];

    // ==========================================================
    // Port K pads
    // ==========================================================
    assign k_in = k_pin_i & k_ie_q;
    assign k_in_o = k_in;
    assign k_pullup_o = k_pu_q;
    assign k_pulldown_o = k_pd_q;

    generate
        for (gi = 0; gi < NK; gi++)
        begin : g_k
            logic drv;
            logic en;
            always_comb
            begin
                drv = k_data_i[gi];
                en = k_oe_i[gi];
                if (gi == 0 && usb_dev_active_i)
                begin
                    drv = usb_dev_pullup_ctrl_i;
                    en = 1'b1;
                end
                else if (gi == 4 && k_fs3_q[gi])
                begin
                    drv = sio0_clock_i;
                    en = sio0_clock_oe_i;
                end
                else if (gi == 3 && k_fs3_q[gi])
                begin
                    drv = sio0_in_or_i2c_clock_i;
                    en = sio0_in_or_i2c_clock_oe_i;
                end
                else if (gi == 2 && k_fs3_q[gi])
                begin
                    drv = sio0_out_or_i2c_data_i;
                    en = sio0_out_or_i2c_data_oe_i;
                end
                else if (gi == 1 && k_fs4_q[gi])
                begin
                    drv = timerb6_output_i;
                    en = 1'b1;
                end
                k_pin_o[gi] = k_od_q[gi] ? 1'b0 : drv;
                k_pin_oe_o[gi] = en && !(k_od_q[gi] && drv);
            end
        end
    endgenerate

    assign sio0_clock_o = k_in[4] & k_fs3_q[4];
    assign sio0_in_or_i2c_clock_o = k_in[3] & k_fs3_q[3];
    assign sio0_out_or_i2c_data_o = k_in[2] & k_fs3_q[2];
    assign ext_interrupt_eight_o = k_in[1] & k_fs3_q[1];
    assign ext_interrupt_d_o = k_in[0] & !usb_dev_active_i;

    // ==========================================================
    // Checks
    // ==========================================================
    chk_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");
    chk_ack_follows_req: assert property (@(posedge clk_i) disable iff (rst_i)
        (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o) else $error("ack missing");
    chk_data_write: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr && wb_adr_i == OFS_L_DATA) |=> l_data_q == $past(wb_dat_i[7:0]))
        else $error("data write lost");
    chk_fs6_bits: assert property (@(posedge clk_i) disable iff (rst_i)
        (l_fs6_q & ~MASK_L_FS6) == 8'h00) else $error("select six stray bit");
    chk_kfs4_bits: assert property (@(posedge clk_i) disable iff (rst_i)
        (k_fs4_q & ~MASK_K_FS4) == 5'h00) else $error("K select four stray bit");
    chk_upper_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |-> wb_dat_o[31:8] == 24'h000000) else $error("upper bits not zero");
    chk_od_low_only: assert property (@(posedge clk_i) disable iff (rst_i)
        (l_od_q != 8'h00) |-> ((l_pin_oe_o & l_od_q & l_pin_o) == 8'h00))
        else $error("open drain drove high");
    chk_input_gate: assert property (@(posedge clk_i) disable iff (rst_i)
        (l_ie_q == 8'h00) |-> (eth_receive_data_o == 4'h0 && !serial2_receive_o))
        else $error("input passed while disabled");
    chk_reset_clear: assert property (@(posedge clk_i)
        $fell(rst_i) |-> (l_oe_q == 8'h00 && k_ie_q == 5'h00 && !wb_ack_o))
        else $error("reset left state");
    chk_oe_drive: assert property (@(posedge clk_i) disable iff (rst_i)
        (l_oe_q[0] && l_fs2_q[0] == 1'b0 && l_fs3_q[0] == 1'b0 && !l_od_q[0])
        |-> (l_pin_oe_o[0] && l_pin_o[0] == l_data_q[0])) else $error("pin 0 not driven");
endmodule : pin_ctrl_kl

// ---- verilog/pin_ctrl_pkg.sv ----
// Purpose: Constants for the port K/L pin control block.
// Assumes: Classic Wishbone slave, 32-bit data, byte addresses.
// Notes: Port K registers sit in a second window of the same slave.
package pin_ctrl_pkg;
    localparam int ADDR_W = 8;
    localparam int L_PINS = 8;
    localparam int K_PINS = 5;
    // Port L register offsets.
    localparam logic [7:0] OFS_L_DATA = 8'h00;
    localparam logic [7:0] OFS_L_OE = 8'h04;
    localparam logic [7:0] OFS_L_FS1 = 8'h08;
    localparam logic [7:0] OFS_L_FS2 = 8'h0C;
    localparam logic [7:0] OFS_L_FS3 = 8'h10;
    localparam logic [7:0] OFS_L_FS4 = 8'h14;
    localparam logic [7:0] OFS_L_FS5 = 8'h18;
    localparam logic [7:0] OFS_L_FS6 = 8'h1C;
    localparam logic [7:0] OFS_L_OD = 8'h28;
    localparam logic [7:0] OFS_L_PU = 8'h2C;
    localparam logic [7:0] OFS_L_PD = 8'h30;
    localparam logic [7:0] OFS_L_IE = 8'h38;
    // Port K register offsets, placed in the upper window.
    localparam logic [7:0] OFS_K_FS3 = 8'h50;
    localparam logic [7:0] OFS_K_FS4 = 8'h54;
    localparam logic [7:0] OFS_K_OD = 8'h68;
    localparam logic [7:0] OFS_K_PU = 8'h6C;
    localparam logic [7:0] OFS_K_PD = 8'h70;
    localparam logic [7:0] OFS_K_IE = 8'h78;
    // Implemented-bit masks.
    localparam logic [7:0] MASK_L_ALL = 8'hFF;
    localparam logic [7:0] MASK_L_LOW4 = 8'h0F;
    localparam logic [7:0] MASK_L_FS5 = 8'h0E;
    localparam logic [7:0] MASK_L_FS6 = 8'h08;
    localparam logic [4:0] MASK_K_ALL = 5'h1F;
    localparam logic [4:0] MASK_K_FS3 = 5'h1E;
    localparam logic [4:0] MASK_K_FS4 = 5'h02;
    localparam logic [7:0] RST_L = 8'h00;
    localparam logic [4:0] RST_K = 5'h00;
    localparam logic [31:0] READ_UNMAPPED = 32'h0000_0000;
endpackage : pin_ctrl_pkg
